// *** hw/asc_host.sv ***
// host controller driving an asynchronous 16-bit static ram
// assumes the ram pins are wired straight, tristate resolved outside
`timescale 1ns/1ps
module asc_host
  import asc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // user side
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [NLANES-1:0] lane_en_i,
  output logic                   ready_o,
  output logic                   rvalid_o,
  output logic      [DATA_W-1:0] rdata_o,
  // ram pins
  output logic      [ADDR_W-1:0] sram_addr_o,
  output logic                   sram_select_active_low_o,
  output logic                   sram_select_active_high_o,
  output logic                   sram_write_strobe_n_o,
  output logic                   sram_output_enable_n_o,
  output logic                   lower_byte_lane_enable_n_o,
  output logic                   upper_byte_lane_enable_n_o,
  input  wire logic [DATA_W-1:0] sram_data_i,
  output logic      [DATA_W-1:0] sram_data_o,
  output logic      [DATA_W-1:0] sram_data_oe_o
);

  asc_state_t        state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [NLANES-1:0] lane_r;
  logic              sel_n_r;
  logic              sel_h_r;
  logic              strb_n_r;
  logic              oe_n_r;
  logic [NLANES-1:0] lane_n_r;
  logic [DATA_W-1:0] doe_r;
  logic              ready_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] din_sync;
  logic [DATA_W-1:0] lane_mask;

  // -------------------------------------------------------------------------
  // synchronised read data
  // -------------------------------------------------------------------------
  asc_sync #(
    .W (DATA_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sram_data_i),
    .q_o   (din_sync)
  );

  // lane mask: low lane bits 0-7, high lane bits 8-15
  assign lane_mask = {{LANE_W{lane_r[1]}}, {LANE_W{lane_r[0]}}}; // [RQ6]

  // -------------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ASC_IDLE;
      cnt_r   <= '0;
      addr_r  <= '0;
      wdata_r <= '0;
      lane_r  <= '0;
    end else begin
      case (state_r)
        ASC_IDLE: begin
          if (req_i && lane_en_i != '0) begin
            addr_r  <= addr_i;
            wdata_r <= wdata_i;
            lane_r  <= lane_en_i;
            // read needs slot for sampling across the synchroniser
            cnt_r   <= we_i ? CNT_W'(1) : CNT_W'(RD_CYC + 3);
            state_r <= we_i ? ASC_WR_SET : ASC_RD;
          end
        end
        ASC_RD: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_W'(1)) begin
            cnt_r   <= CNT_W'(HZ_CYC);
            state_r <= ASC_RD_OFF;
          end
        end
        ASC_RD_OFF: begin
          // wait for the ram to release the pins before anything else
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_W'(1)) begin
            state_r <= ASC_IDLE; // [RQ5]
          end
        end
        ASC_WR_SET: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_W'(1)) begin
            cnt_r   <= CNT_W'(WP_CYC);
            state_r <= ASC_WR_PULSE;
          end
        end
        ASC_WR_PULSE: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_W'(1)) begin
            cnt_r   <= CNT_W'(WR_CYC + 1);
            state_r <= ASC_WR_REC;
          end
        end
        ASC_WR_REC: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_W'(1)) begin
            state_r <= ASC_IDLE;
          end
        end
        default: begin
          state_r <= ASC_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // control strobes, registered from the state, the count and the request
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_n_r  <= SEL_N_IDLE;
      sel_h_r  <= SEL_H_IDLE;
      strb_n_r <= STRB_N_IDLE;
      oe_n_r   <= OE_N_IDLE;
      lane_n_r <= LANE_N_IDLE;
    end else begin
      case (state_r)
        ASC_IDLE: begin
          // idle is standby: selects and lanes inactive
          sel_n_r  <= SEL_N_IDLE; // [RQ2]
          sel_h_r  <= SEL_H_IDLE; // [RQ2]
          strb_n_r <= STRB_N_IDLE;
          oe_n_r   <= OE_N_IDLE;
          lane_n_r <= LANE_N_IDLE;
          if (req_i && lane_en_i != '0) begin
            sel_n_r  <= 1'b0;
            sel_h_r  <= 1'b1;
            lane_n_r <= ~lane_en_i; // [RQ6]
            // read: strobe stays high, output enable low
            oe_n_r   <= we_i; // [RQ1]
          end
        end
        ASC_RD: begin
          if (cnt_r == CNT_W'(1)) begin
            sel_n_r  <= SEL_N_IDLE;
            sel_h_r  <= SEL_H_IDLE;
            oe_n_r   <= OE_N_IDLE;
            lane_n_r <= LANE_N_IDLE;
          end
        end
        ASC_WR_SET: begin
          // selects went active a cycle before strobe fall, output enable
          // held high so the ram never turns its drivers on
          if (cnt_r == CNT_W'(1)) begin
            strb_n_r <= 1'b0; // [RQ3] [RQ4]
          end
        end
        ASC_WR_PULSE: begin
          if (cnt_r == CNT_W'(1)) begin
            strb_n_r <= STRB_N_IDLE; // [RQ3]
          end
        end
        ASC_WR_REC: begin
          if (cnt_r == CNT_W'(1)) begin
            sel_n_r  <= SEL_N_IDLE;
            sel_h_r  <= SEL_H_IDLE;
            lane_n_r <= LANE_N_IDLE;
          end
        end
        default: begin
          sel_n_r  <= SEL_N_IDLE;
          sel_h_r  <= SEL_H_IDLE;
          strb_n_r <= STRB_N_IDLE;
          oe_n_r   <= OE_N_IDLE;
          lane_n_r <= LANE_N_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // host data drive: only during a write, only on enabled lanes
  // -------------------------------------------------------------------------
  // data stays on one cycle past the strobe rise, so the ram never latches
  // a bus that is being released in the same instant
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      doe_r <= '0;
    end else if (state_r == ASC_WR_SET || state_r == ASC_WR_PULSE) begin
      doe_r <= lane_mask; // [RQ5]
    end else begin
      doe_r <= '0;
    end
  end

  // -------------------------------------------------------------------------
  // user handshake and read capture
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
    end else begin
      ready_r  <= (state_r == ASC_IDLE) && !req_i;
      rvalid_r <= 1'b0;
      if (state_r == ASC_RD && cnt_r == CNT_W'(1)) begin
        rvalid_r <= 1'b1;
        rdata_r  <= din_sync & lane_mask; // [RQ7]
      end
    end
  end

  assign ready_o                    = ready_r;
  assign rvalid_o                   = rvalid_r;
  assign rdata_o                    = rdata_r;
  assign sram_addr_o                = addr_r;
  assign sram_select_active_low_o   = sel_n_r;
  assign sram_select_active_high_o  = sel_h_r;
  assign sram_write_strobe_n_o      = strb_n_r;
  assign sram_output_enable_n_o     = oe_n_r;
  assign lower_byte_lane_enable_n_o = lane_n_r[0];
  assign upper_byte_lane_enable_n_o = lane_n_r[1];
  assign sram_data_o                = wdata_r;
  assign sram_data_oe_o             = doe_r;

endmodule : asc_host

// *** common/asc_pkg.sv ***
// package for the asynchronous static ram host controller
// assumes a 100 MHz clock and one 16-bit static ram on the pins
//
// Functional notes
// [RQ1] read: strobe high, output enable low, selects active, a byte lane on
// [RQ2] low select low, high select high, byte lanes low mean active
// [RQ3] write happens while strobe, both selects and a byte lane are active
// [RQ4] selects active with or after strobe fall keep device data pins undriven
// [RQ5] host must not drive data while the device may still drive the pins
// [RQ6] lower lane enable maps data 0-7, upper maps 8-15, both active low
// [RQ7] device leaves unselected lanes and idle states undriven
package asc_pkg;

  // -------------------------------------------------------------------------
  // bus geometry
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int NLANES = 2;

  // -------------------------------------------------------------------------
  // timing figures in ns and derived cycle counts
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RC_NS       = 70;  // read cycle, least
  localparam int T_WC_NS       = 70;  // write cycle, least
  localparam int T_WP_NS       = 50;  // write pulse, least
  localparam int T_DW_NS       = 30;  // data overlap before strobe rise
  localparam int T_OHZ_NS      = 30;  // output off after output disable, most
  localparam int T_WR_NS       = 0;   // write recovery, least
  localparam int RD_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DW_CYC  = (T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC  = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC  = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1
                           ? 1
                           : (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W   = 4;

  // -------------------------------------------------------------------------
  // reset values of pins
  // -------------------------------------------------------------------------
  localparam logic        SEL_N_IDLE  = 1'b1;
  localparam logic        SEL_H_IDLE  = 1'b0;
  localparam logic        STRB_N_IDLE = 1'b1;
  localparam logic        OE_N_IDLE   = 1'b1;
  localparam logic [1:0]  LANE_N_IDLE = 2'h3;

  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_RD,
    ASC_RD_OFF,
    ASC_WR_SET,
    ASC_WR_PULSE,
    ASC_WR_REC
  } asc_state_t;

endpackage : asc_pkg

// *** hw/asc_sync.sv ***
// three-stage synchroniser for the data pins coming back from the ram
// assumes the ram drives asynchronously to clk_i
`timescale 1ns/1ps
module asc_sync
  import asc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  // -------------------------------------------------------------------------
  // per bit: change is taken when second and third stage agree
  // -------------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        q_r[i]  <= 1'b0;
      end else begin
        s1_r[i] <= d_i[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign q_o = q_r;

endmodule : asc_sync

// *** bench/asc_host_assertions.sv ***
// checker for the static ram host controller pins
// assumes it is bound to asc_host and sees only its ports
`timescale 1ns/1ps
module asc_host_assertions
  import asc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              rvalid_o,
  input  wire logic              sram_select_active_low_o,
  input  wire logic              sram_select_active_high_o,
  input  wire logic              sram_write_strobe_n_o,
  input  wire logic              sram_output_enable_n_o,
  input  wire logic              lower_byte_lane_enable_n_o,
  input  wire logic              upper_byte_lane_enable_n_o,
  input  wire logic [DATA_W-1:0] sram_data_oe_o
);
  // short aliases of the pins
  wire sn = sram_select_active_low_o;
  wire sh = sram_select_active_high_o;
  wire wn = sram_write_strobe_n_o;
  wire on = sram_output_enable_n_o;
  wire ln = lower_byte_lane_enable_n_o;
  wire un = upper_byte_lane_enable_n_o;
  wire [DATA_W-1:0] doe = sram_data_oe_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_sel_pair: assert property (
    sn == !sh) else $error("selects disagree");
  a_write_gated: assert property (
    !wn |-> !sn && sh && !(ln && un)) else $error("strobe outside select");
  a_no_read_write: assert property (
    !wn |-> on) else $error("output enable during write");
  a_drive_in_write: assert property (
    (|doe) |-> !sn && on) else $error("host drives outside write");
  a_sel_lead: assert property (
    $fell(wn) |-> $past(sn) == 1'b0) else $error("select late");
  a_pulse_len: assert property (
    $fell(wn) |-> !wn [*5] ##1 wn) else $error("strobe pulse length");
  a_read_answer: assert property (
    $fell(on) |-> wn && !sn ##10 rvalid_o) else $error("read answer late");
  a_lane_map: assert property (
    (!(|doe[7:0]) || !ln) && (!(|doe[15:8]) || !un))
    else $error("lane drive without enable");
  a_data_overlap: assert property (
    $rose(wn) |-> doe != 16'h0) else $error("data gone at strobe end");
endmodule : asc_host_assertions

bind asc_host asc_host_assertions i_asc_host_assertions (
  .clk_i, .rst_i, .rvalid_o, .sram_select_active_low_o,
  .sram_select_active_high_o, .sram_write_strobe_n_o,
  .sram_output_enable_n_o, .lower_byte_lane_enable_n_o,
  .upper_byte_lane_enable_n_o, .sram_data_oe_o);

// *** bench/asc_sram_model.sv ***
// behavioural static ram die: 256 words, two byte lanes
// assumes host pins wired straight; resolves the shared data bus
`timescale 1ns/1ps
module asc_sram_model (
  input  wire logic        sn_i,
  input  wire logic        sh_i,
  input  wire logic        wn_i,
  input  wire logic        on_i,
  input  wire logic        ln_i,
  input  wire logic        un_i,
  input  wire logic [17:0] a_i,
  input  wire logic [15:0] hd_i,
  input  wire logic [15:0] hoe_i,
  output logic      [15:0] bus_o,
  output logic             clash_o
);
  logic [15:0] mem [0:255];
  logic [15:0] den;
  logic [15:0] last;
  logic        act;
  logic        rd;
  // device mode from the strobes
  assign act = !sn_i && sh_i;
  assign rd  = act && wn_i && !on_i && !(ln_i && un_i);
  assign den = rd ? {{8{!un_i}}, {8{!ln_i}}} : 16'h0;
  // released lines show the inverse of the last device data
  assign bus_o = (hoe_i & hd_i) | (~hoe_i & den & mem[a_i[7:0]])
               | (~hoe_i & ~den & ~last);
  initial begin
    clash_o = 1'b0;
    last = 16'h0;
    foreach (mem[i]) mem[i] = 16'h0;
  end
  always @(negedge rd) last = mem[a_i[7:0]];
  // both parties driving one line
  always @(hoe_i or den) if ((hoe_i & den) != 16'h0) clash_o = 1'b1;
  // store the enabled lanes as the strobe ends
  always @(posedge wn_i) begin
    if (act && !ln_i) mem[a_i[7:0]][7:0] = bus_o[7:0];
    if (act && !un_i) mem[a_i[7:0]][15:8] = bus_o[15:8];
  end
endmodule : asc_sram_model

// *** bench/asc_host_tb.sv ***
// self-checking bench for the static ram host controller
// assumes the ram model on the pins and a 100 MHz clock
`timescale 1ns/1ps
module asc_host_tb
  import asc_pkg::*;
;
  logic clk_i, rst_i, req_i, we_i, ready_o, rvalid_o, clash;
  logic [17:0] addr_i, sram_addr_o;
  logic [15:0] wdata_i, rdata_o, sram_data_i, sram_data_o, sram_data_oe_o;
  logic [1:0] lane_en_i;
  logic sn, sh, wn, on, ln, un;
  int mismatches = 0;
  int checked = 0;
  asc_host i_asc_host (.clk_i, .rst_i, .req_i, .we_i, .addr_i, .wdata_i,
    .lane_en_i, .ready_o, .rvalid_o, .rdata_o, .sram_addr_o,
    .sram_select_active_low_o(sn), .sram_select_active_high_o(sh),
    .sram_write_strobe_n_o(wn), .sram_output_enable_n_o(on),
    .lower_byte_lane_enable_n_o(ln), .upper_byte_lane_enable_n_o(un),
    .sram_data_i, .sram_data_o, .sram_data_oe_o);
  asc_sram_model i_asc_sram_model (.sn_i(sn), .sh_i(sh), .wn_i(wn),
    .on_i(on), .ln_i(ln), .un_i(un), .a_i(sram_addr_o), .hd_i(sram_data_o),
    .hoe_i(sram_data_oe_o), .bus_o(sram_data_i), .clash_o(clash));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("%0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // one request pulse, taken at the following rising edge
  task automatic go(input logic w, input logic [17:0] a,
                    input logic [15:0] d, input logic [1:0] l);
    @(negedge clk_i);
    req_i = 1'b1;
    we_i = w;
    addr_i = a;
    wdata_i = d;
    lane_en_i = l;
    @(negedge clk_i);
    req_i = 1'b0;
  endtask : go
  task automatic wr(input logic [17:0] a, input logic [15:0] d,
                    input logic [1:0] l);
    go(1'b1, a, d, l);
    repeat (9) @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [1:0] l,
                    input logic [15:0] e);
    int n;
    go(1'b0, a, 16'h0, l);
    n = 1;
    while (rvalid_o !== 1'b1 && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    chk(16'(n), 16'h000b);
    chk(rdata_o, e);
    repeat (2) @(negedge clk_i);
  endtask : rd
  task automatic t_idle();
    chk({10'h0, sn, sh, wn, on, ln, un}, 16'h002f);
    chk(sram_data_oe_o, 16'h0);
    @(negedge clk_i);
    chk({15'h0, ready_o}, 16'h0001);
    $display("idle test done");
  endtask : t_idle
  task automatic t_lanes();
    wr(18'h00012, 16'ha55a, 2'h3);
    rd(18'h00012, 2'h3, 16'ha55a);
    wr(18'h00012, 16'h1234, 2'h1);
    rd(18'h00012, 2'h3, 16'ha534);
    rd(18'h00012, 2'h2, 16'ha500);
    wr(18'h00012, 16'hbeef, 2'h2);
    rd(18'h00012, 2'h1, 16'h0034);
    $display("lane test done");
  endtask : t_lanes
  task automatic t_refuse();
    go(1'b1, 18'h00012, 16'hffff, 2'h0);
    repeat (9) begin
      @(negedge clk_i);
      chk({15'h0, sn}, 16'h0001);
    end
    go(1'b1, 18'h00014, 16'h1111, 2'h3);
    go(1'b1, 18'h00014, 16'h2222, 2'h3);
    repeat (8) @(negedge clk_i);
    rd(18'h00014, 2'h3, 16'h1111);
    rd(18'h00012, 2'h3, 16'hbe34);
    chk({15'h0, clash}, 16'h0000);
    $display("refusal test done");
  endtask : t_refuse
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    req_i = 1'b0;
    we_i = 1'b0;
    addr_i = 18'h0;
    wdata_i = 16'h0;
    lane_en_i = 2'h0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_idle();
    t_lanes();
    t_refuse();
    conclude();
  end
endmodule : asc_host_tb
